// [logic/pptc_defines.svh]
// offsets, field positions, reset values and timing figures of the ptp time clock
`ifndef PPTC_DEFINES_SVH
`define PPTC_DEFINES_SVH

// register indices, byte address is four times the index
`define PPTC_IDX_CTRL 14'h0500
`define PPTC_IDX_PHASE 14'h0502
`define PPTC_IDX_NS_HI 14'h0504
`define PPTC_IDX_NS_LO 14'h0506
`define PPTC_IDX_SEC_HI 14'h0508
`define PPTC_IDX_SEC_LO 14'h050a
`define PPTC_IDX_RATE_HI 14'h050c
`define PPTC_IDX_RATE_LO 14'h050e
`define PPTC_IDX_DUR_HI 14'h0510
`define PPTC_IDX_DUR_LO 14'h0512

// control word fields
`define PPTC_CTRL_CONT 2
`define PPTC_CTRL_LOAD 3
`define PPTC_CTRL_READ 4

// rate upper word fields
`define PPTC_RATE_DIR 15
`define PPTC_RATE_TEMP 14
`define PPTC_RATE_HI_MSB 13

// phase field
`define PPTC_PHASE_MAX 3'h4
`define PPTC_PHASE_RST 3'h0

// reset values of the words
`define PPTC_WORD_RST 16'h0000
`define PPTC_LONG_RST 32'h0000_0000
`define PPTC_RATE_RST 30'h0000_0000

// timing: system clock period, rtc tick period, one second
`define PPTC_CLK_PERIOD_NS 7'd25
`define PPTC_TICK_NS 7'd40
`define PPTC_NS_PER_SEC 33'd1000000000

// bus answers
`define PPTC_RESP_OKAY 2'h0
`define PPTC_RESP_SLVERR 2'h2

`endif

// [logic/pptc_pkg.sv]
// types of the ptp time clock with rate adjustment
package pptc_pkg;

    // bus channel state, gray along idle -> answer
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_RESP = 2'b01
    } pptc_bus_e;

    // whole state of the time clock top
    typedef struct packed {
        pptc_bus_e wr_st;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [13:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        pptc_bus_e rd_st;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [2:0] sh_phase;
        logic [31:0] sh_ns;
        logic [31:0] sh_sec;
        logic rate_dir;
        logic temp_on;
        logic cont;
        logic [29:0] rate;
        logic [31:0] dur;
        logic [2:0] phase;
        logic [31:0] ns;
        logic [31:0] sec;
        logic [29:0] frac;
        logic [31:0] tleft;
    } pptc_state_s;

    // state of the tick divider
    typedef struct packed {
        logic [6:0] acc;
        logic tick;
    } pptc_tick_s;

endpackage

// [logic/pptc_tick_gen.sv]
// fractional divider giving the 25 mhz rtc tick as an enable on the 40 mhz clock
`timescale 1ns/1ps
`include "pptc_defines.svh"

module pptc_tick_gen (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // one-cycle enable, five of every eight clocks
    output logic tick
);
    import pptc_pkg::*;

    pptc_tick_s r; // registered state
    pptc_tick_s n; // next state

    // add the clock period each cycle, tick when a whole rtc period is due
    always_comb begin
        n = r;
        n.tick = 1'b0;
        if (r.acc + `PPTC_CLK_PERIOD_NS >= `PPTC_TICK_NS) begin
            n.acc = r.acc + `PPTC_CLK_PERIOD_NS - `PPTC_TICK_NS;
            n.tick = 1'b1;
        end else begin
            n.acc = r.acc + `PPTC_CLK_PERIOD_NS;
        end
    end

    // register the copy
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = r.tick;
endmodule

// [logic/pptc_time_clock.sv]
// ptp real time clock with continuous and timed rate adjustment, axi4-lite registers
// Operation
// - phase field names 8 ns slot in tick
// - phase codes 000..100 mean 0..32 ns
// - phase codes 101..111 never reported nor accepted
// - nanoseconds 32 bits, two read-write halves
// - seconds 32 bits, two read-write halves
// - direction one adds rate each tick
// - direction zero subtracts rate each tick
// - direction bit serves both adjustment modes
// - temporary bit starts timed rate adjustment
// - writing temporary bit zero stops it
// - duration 32 bit tick count, upper word
// - rate 30 bits over two words
// - one rate value for both modes
// - read strobe copies live clock to words
// - load strobe copies words to live clock
// - continuous mode adjusts every tick, no limit
// - duration lower word, resets zero
`timescale 1ns/1ps
`include "pptc_defines.svh"

module pptc_time_clock (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // axi4-lite write address
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // live time for the rest of the switch
    output logic [31:0] rtc_seconds,
    output logic [31:0] rtc_nanoseconds,
    output logic [2:0] rtc_phase
);
    import pptc_pkg::*;

    pptc_state_s r; // registered state
    pptc_state_s n; // next state
    logic tick; // 25 mhz enable
    logic wr_do; // both write halves held, commit now
    logic adj; // some adjustment mode active
    logic [30:0] fsum; // fraction sum with carry or borrow
    logic [32:0] nsn; // advanced nanoseconds before wrap
    logic [6:0] step; // nanoseconds added this tick
    logic ld_req; // load strobe in this write
    logic rd_req; // read strobe in this write
    logic [31:0] rmux; // read word for the pending address
    logic rmap; // pending read address is mapped
    logic wmap; // pending write address is mapped

    // tick divider
    pptc_tick_gen u_tick (
        .clk(clk),
        .reset(reset),
        .tick(tick)
    );

    // byte-lane merge of a 16-bit word
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // read mux over the register map, unmapped words read zero
    always_comb begin
        rmap = 1'b1;
        rmux = 32'h0000_0000;
        case (s_axi_araddr[15:2])
            `PPTC_IDX_CTRL: rmux = {29'h0, r.cont, 2'h0};
            `PPTC_IDX_PHASE: rmux = {29'h0, r.sh_phase};
            `PPTC_IDX_NS_HI: rmux = {16'h0, r.sh_ns[31:16]};
            `PPTC_IDX_NS_LO: rmux = {16'h0, r.sh_ns[15:0]};
            `PPTC_IDX_SEC_HI: rmux = {16'h0, r.sh_sec[31:16]};
            `PPTC_IDX_SEC_LO: rmux = {16'h0, r.sh_sec[15:0]};
            `PPTC_IDX_RATE_HI: rmux = {16'h0, r.rate_dir, r.temp_on, r.rate[29:16]};
            `PPTC_IDX_RATE_LO: rmux = {16'h0, r.rate[15:0]};
            `PPTC_IDX_DUR_HI: rmux = {16'h0, r.dur[31:16]};
            `PPTC_IDX_DUR_LO: rmux = {16'h0, r.dur[15:0]};
            default: rmap = 1'b0;
        endcase
    end

    // write decode: only indices in the map answer okay
    always_comb begin
        case (r.waddr)
            `PPTC_IDX_CTRL, `PPTC_IDX_PHASE, `PPTC_IDX_NS_HI, `PPTC_IDX_NS_LO,
            `PPTC_IDX_SEC_HI, `PPTC_IDX_SEC_LO, `PPTC_IDX_RATE_HI, `PPTC_IDX_RATE_LO,
            `PPTC_IDX_DUR_HI, `PPTC_IDX_DUR_LO: wmap = 1'b1;
            default: wmap = 1'b0;
        endcase
    end

    assign wr_do = r.aw_got && r.w_got;
    assign ld_req = wr_do && r.waddr == `PPTC_IDX_CTRL && r.wstrb[0]
                    && r.wdata[`PPTC_CTRL_LOAD];
    assign rd_req = wr_do && r.waddr == `PPTC_IDX_CTRL && r.wstrb[0]
                    && r.wdata[`PPTC_CTRL_READ];
    // one rate and one direction serve both modes
    assign adj = r.cont || r.temp_on;

    // rate step: fraction carry or borrow moves the nanoseconds by one
    always_comb begin
        if (adj && r.rate_dir) begin
            fsum = {1'b0, r.frac} + {1'b0, r.rate};
            step = `PPTC_TICK_NS + {6'h0, fsum[30]};
        end else if (adj) begin
            fsum = {1'b0, r.frac} - {1'b0, r.rate};
            step = `PPTC_TICK_NS - {6'h0, fsum[30]};
        end else begin
            fsum = {1'b0, r.frac};
            step = `PPTC_TICK_NS;
        end
        nsn = {1'b0, r.ns} + {26'h0, step};
    end

    // next state: bus, registers, live clock
    always_comb begin
        n = r;
        // write address and data taken in either order
        if (s_axi_awvalid && r.awready) begin
            n.awready = 1'b0;
            n.aw_got = 1'b1;
            n.waddr = s_axi_awaddr[15:2];
        end
        if (s_axi_wvalid && r.wready) begin
            n.wready = 1'b0;
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        // answer after both halves, ready returns once it is taken
        if (r.wr_st == BUS_RESP && s_axi_bready) begin
            n.bvalid = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
            n.wr_st = BUS_IDLE;
        end
        // live clock advances by one tick
        if (tick) begin
            n.frac = fsum[29:0];
            if (nsn >= `PPTC_NS_PER_SEC) begin
                n.ns = 32'(nsn - `PPTC_NS_PER_SEC);
                n.sec = r.sec + 32'h0000_0001;
            end else begin
                n.ns = nsn[31:0];
            end
            // timed mode counts down and ends itself
            if (r.temp_on) begin
                n.tleft = r.tleft - 32'h0000_0001;
                if (r.tleft == 32'h0000_0001) begin
                    n.temp_on = 1'b0;
                end
            end
        end
        // read strobe takes the clock as it stood before this tick
        if (rd_req) begin
            n.sh_phase = r.phase;
            n.sh_ns = r.ns;
            n.sh_sec = r.sec;
        end
        // load strobe wins over the tick in the same cycle
        if (ld_req) begin
            n.phase = r.sh_phase;
            n.ns = r.sh_ns;
            n.sec = r.sh_sec;
            n.frac = `PPTC_RATE_RST;
        end
        // commit a write, registers win over hardware updates
        if (wr_do) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.wr_st = BUS_RESP;
            n.bresp = wmap ? `PPTC_RESP_OKAY : `PPTC_RESP_SLVERR;
            case (r.waddr)
                `PPTC_IDX_CTRL: begin
                    if (r.wstrb[0]) begin
                        n.cont = r.wdata[`PPTC_CTRL_CONT];
                    end
                end
                `PPTC_IDX_PHASE: begin
                    // an invalid code is held at the last valid slot
                    if (r.wstrb[0]) begin
                        n.sh_phase = (r.wdata[2:0] > `PPTC_PHASE_MAX) ?
                                     `PPTC_PHASE_MAX : r.wdata[2:0];
                    end
                end
                `PPTC_IDX_NS_HI: n.sh_ns[31:16] = merge16(r.sh_ns[31:16], r.wdata, r.wstrb);
                `PPTC_IDX_NS_LO: n.sh_ns[15:0] = merge16(r.sh_ns[15:0], r.wdata, r.wstrb);
                `PPTC_IDX_SEC_HI: n.sh_sec[31:16] = merge16(r.sh_sec[31:16], r.wdata, r.wstrb);
                `PPTC_IDX_SEC_LO: n.sh_sec[15:0] = merge16(r.sh_sec[15:0], r.wdata, r.wstrb);
                `PPTC_IDX_RATE_HI: begin
                    if (r.wstrb[0]) begin
                        n.rate[23:16] = r.wdata[7:0];
                    end
                    if (r.wstrb[1]) begin
                        n.rate[29:24] = r.wdata[`PPTC_RATE_HI_MSB:8];
                        n.rate_dir = r.wdata[`PPTC_RATE_DIR];
                        // a zero duration gives no timed adjustment at all
                        n.temp_on = r.wdata[`PPTC_RATE_TEMP] && r.dur != 32'h0;
                        n.tleft = r.dur;
                    end
                end
                `PPTC_IDX_RATE_LO: n.rate[15:0] = merge16(r.rate[15:0], r.wdata, r.wstrb);
                `PPTC_IDX_DUR_HI: n.dur[31:16] = merge16(r.dur[31:16], r.wdata, r.wstrb);
                `PPTC_IDX_DUR_LO: n.dur[15:0] = merge16(r.dur[15:0], r.wdata, r.wstrb);
                default: n.bresp = `PPTC_RESP_SLVERR;
            endcase
        end
        // read channel: one read at a time
        case (r.rd_st)
            BUS_IDLE: begin
                if (s_axi_arvalid) begin
                    n.arready = 1'b0;
                    n.rvalid = 1'b1;
                    n.rdata = rmux;
                    n.rresp = rmap ? `PPTC_RESP_OKAY : `PPTC_RESP_SLVERR;
                    n.rd_st = BUS_RESP;
                end
            end
            BUS_RESP: begin
                if (s_axi_rready) begin
                    n.rvalid = 1'b0;
                    n.arready = 1'b1;
                    n.rd_st = BUS_IDLE;
                end
            end
            default: n.rd_st = BUS_IDLE;
        endcase
    end

    // register the copy; ready flags come up at reset
    always_ff @(posedge clk) begin
        if (reset) begin
            r <= '0;
            r.awready <= 1'b1;
            r.wready <= 1'b1;
            r.arready <= 1'b1;
            r.phase <= `PPTC_PHASE_RST;
            r.sh_phase <= `PPTC_PHASE_RST;
        end else begin
            r <= n;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = r.awready;
    assign s_axi_wready = r.wready;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arready;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign rtc_seconds = r.sec;
    assign rtc_nanoseconds = r.ns;
    assign rtc_phase = r.phase;

    // checks, all on clk
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic rate_wr; // write of the rate upper word, high lane
    logic quiet; // tick without load and far from a second wrap
    assign rate_wr = wr_do && r.waddr == `PPTC_IDX_RATE_HI && r.wstrb[1];
    assign quiet = tick && !ld_req && r.ns < 32'd999_000_000;

    sequence s_tick_adj(d);
        quiet && adj && r.rate_dir == d && !rate_wr;
    endsequence

    AST_PHASE_OK: assert property (r.phase <= `PPTC_PHASE_MAX
        && r.sh_phase <= `PPTC_PHASE_MAX)
        else $error("phase code out of range");
    AST_NOMINAL: assert property (quiet && !adj |=> r.ns == $past(r.ns) + 32'd40)
        else $error("nominal tick not 40 ns");
    AST_ADD: assert property (s_tick_adj(1'b1) |=>
        {r.ns, r.frac} == $past({r.ns, r.frac}) + {32'd40, $past(r.rate)})
        else $error("rate not added");
    AST_SUB: assert property (s_tick_adj(1'b0) |=>
        {r.ns, r.frac} == $past({r.ns, r.frac}) + {32'd40, 30'h0} - {32'd0, $past(r.rate)})
        else $error("rate not subtracted");
    AST_TEMP_START: assert property (rate_wr && r.wdata[14] && r.dur != 32'h0
        |=> r.temp_on && r.tleft == $past(r.dur))
        else $error("timed adjustment did not start");
    AST_TEMP_STOP: assert property (rate_wr && !r.wdata[14] |=> !r.temp_on [*2])
        else $error("timed adjustment did not stop");
    AST_TEMP_END: assert property (tick && r.temp_on && r.tleft == 32'h1 && !rate_wr
        |=> !r.temp_on)
        else $error("timed adjustment overran");
    AST_READ: assert property (rd_req
        |=> r.sh_ns == $past(r.ns) && r.sh_sec == $past(r.sec) && r.sh_phase == $past(r.phase))
        else $error("read strobe did not capture");
    AST_LOAD: assert property (ld_req && !rd_req |=>
        r.ns == $past(r.sh_ns) && r.sec == $past(r.sh_sec) && r.phase == $past(r.sh_phase))
        else $error("load strobe did not load");
    AST_CONT: assert property (r.cont && !r.temp_on && quiet && r.rate != 30'h0
        |=> r.frac != $past(r.frac))
        else $error("continuous mode idle");
    // bus answers stand until the master takes them
    AST_B_HOLD: assert property (r.bvalid && !s_axi_bready
        |=> r.bvalid && $stable(r.bresp))
        else $error("write answer dropped early");
    AST_R_HOLD: assert property (r.rvalid && !s_axi_rready
        |=> r.rvalid && $stable(r.rdata) && $stable(r.rresp))
        else $error("read answer dropped early");
    AST_B_DONE: assert property (r.bvalid && s_axi_bready
        |=> !r.bvalid && r.awready && r.wready)
        else $error("write channel not reopened");
    AST_AR_TAKE: assert property (r.arready && s_axi_arvalid
        |=> r.rvalid && !r.arready)
        else $error("read not answered next cycle");
    // timed mode bookkeeping, a zero duration never starts it
    AST_DUR_ZERO: assert property (rate_wr && r.dur == 32'h0 |=> !r.temp_on)
        else $error("zero duration started adjustment");
    AST_TEMP_COUNT: assert property (tick && r.temp_on && r.tleft != 32'h1 && !rate_wr
        |=> r.temp_on && r.tleft == $past(r.tleft) - 32'h1)
        else $error("timed count did not step");
    // continuous bit storage and the carry into seconds
    AST_CONT_SET: assert property (wr_do && r.waddr == `PPTC_IDX_CTRL && r.wstrb[0]
        |=> r.cont == $past(r.wdata[`PPTC_CTRL_CONT]))
        else $error("continuous bit not stored");
    AST_SEC_CARRY: assert property (tick && !ld_req && nsn >= `PPTC_NS_PER_SEC
        |=> r.sec == $past(r.sec) + 32'h1)
        else $error("second not carried");
endmodule

// [dv/ptp_time_clock_rate_adjust_test.sv]
// self-checking bench of the ptp time clock with rate adjustment
`timescale 1ns/1ps
`include "pptc_defines.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end

module ptp_time_clock_rate_adjust_test;
    // clock, reset and bus drive
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] awaddr = 16'h0000;
    logic [15:0] araddr = 16'h0000;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    // design answers
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, sec, ns;
    logic [2:0] phase;
    // bookkeeping; ns span of 800 clocks always holds 500 ticks
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;
    int c0;
    logic [31:0] n0, s0, v;
    logic [13:0] regs [8] = '{`PPTC_IDX_NS_HI, `PPTC_IDX_NS_LO, `PPTC_IDX_SEC_HI,
        `PPTC_IDX_SEC_LO, `PPTC_IDX_RATE_LO, `PPTC_IDX_DUR_HI, `PPTC_IDX_DUR_LO,
        `PPTC_IDX_RATE_HI};

    pptc_time_clock uut (.clk(clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rtc_seconds(sec),
        .rtc_nanoseconds(ns), .rtc_phase(phase));

    // 40 mhz clock and a cycle count for timed spans
    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    // verdict and end of run
    task automatic close_out;
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // a wait that ran out counts as a mismatch
    task automatic guard(inout int n);
        n++;
        if (n > 60) begin
            err_count++;
            $display("BAD %0t bus wait ran out", $time);
            close_out();
        end
    endtask

    // one axi write; readies sampled at negedge, as they are registers
    task automatic wr(input logic [13:0] i, input logic [15:0] d, input logic [1:0] er);
        int n;
        logic ad, wd, bd;
        logic [1:0] r;
        n = 0;
        ad = 1'b0;
        wd = 1'b0;
        bd = 1'b0;
        @(posedge clk);
        awaddr <= {i, 2'b00};
        wdata <= {16'($urandom), d};
        wstrb <= {2'($urandom), 2'b11};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!bd) begin
            @(negedge clk);
            if (ad && wd) bd = bvalid;
            r = bresp;
            if (awvalid && awready) ad = 1'b1;
            if (wvalid && wready) wd = 1'b1;
            @(posedge clk);
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
            guard(n);
        end
        bready <= 1'b0;
        `CHK(r, er)
    endtask

    // one axi read; data taken at the edge that sees rvalid
    task automatic rd(input logic [13:0] i, input logic [1:0] er, output logic [31:0] d);
        int n;
        logic ad, dd;
        logic [1:0] r;
        n = 0;
        ad = 1'b0;
        dd = 1'b0;
        @(posedge clk);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!dd) begin
            @(negedge clk);
            if (ad) dd = rvalid;
            if (arvalid && arready) ad = 1'b1;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ad) arvalid <= 1'b0;
            guard(n);
        end
        rready <= 1'b0;
        `CHK(r, er)
    endtask

    // load the live clock from the words; ctrl bits beside load kept
    task automatic ld(input logic [31:0] s, input logic [31:0] n, input logic [2:0] p,
            input logic [15:0] c);
        wr(`PPTC_IDX_NS_HI, n[31:16], `PPTC_RESP_OKAY);
        wr(`PPTC_IDX_NS_LO, n[15:0], `PPTC_RESP_OKAY);
        wr(`PPTC_IDX_SEC_HI, s[31:16], `PPTC_RESP_OKAY);
        wr(`PPTC_IDX_SEC_LO, s[15:0], `PPTC_RESP_OKAY);
        wr(`PPTC_IDX_PHASE, {13'h0, p}, `PPTC_RESP_OKAY);
        wr(`PPTC_IDX_CTRL, c | 16'h0008, `PPTC_RESP_OKAY);
        @(negedge clk);
        `CHK(sec, s)
        `CHK(phase, p)
    endtask

    // rate of k quarter nanoseconds, so 500 ticks give an exact shift
    task automatic rate(input logic dir, input logic tmp, input logic [1:0] k);
        wr(`PPTC_IDX_RATE_LO, 16'h0000, `PPTC_RESP_OKAY);
        wr(`PPTC_IDX_RATE_HI, {dir, tmp, k, 12'h000}, `PPTC_RESP_OKAY);
    endtask

    // start and end of an 800 clock span
    task automatic mark;
        @(negedge clk);
        n0 = ns;
        s0 = sec;
        c0 = cyc;
    endtask
    task automatic span;
        while (cyc < c0 + 800) @(negedge clk);
    endtask

    // expected nanoseconds after 500 ticks plus an adjustment
    function automatic logic [31:0] exp_ns(input logic [31:0] n, input int adj);
        logic [32:0] t;
        t = 33'(n) + 33'(20000 + adj);
        if (t >= `PPTC_NS_PER_SEC) t = t - `PPTC_NS_PER_SEC;
        return t[31:0];
    endfunction

    // main sequence
    initial begin
        logic [15:0] w;
        logic [1:0] k;
        int dv;
        void'($urandom(32'hc050));
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        // reset values, then random write and read back
        for (int j = 0; j < 8; j++) begin
            rd(regs[j], `PPTC_RESP_OKAY, v);
            `CHK(v, 32'h0)
            w = 16'($urandom);
            if (j == 7) w[14] = 1'b0;
            wr(regs[j], w, `PPTC_RESP_OKAY);
            rd(regs[j], `PPTC_RESP_OKAY, v);
            `CHK(v, {16'h0, w})
        end
        // every phase code, invalid ones held at the top code
        for (int p = 0; p < 8; p++) begin
            wr(`PPTC_IDX_PHASE, 16'(p), `PPTC_RESP_OKAY);
            rd(`PPTC_IDX_PHASE, `PPTC_RESP_OKAY, v);
            `CHK(v, (p > 4) ? 32'h4 : 32'(p))
        end
        // unmapped place refused both ways
        wr(14'h0600, 16'h1234, `PPTC_RESP_SLVERR);
        rd(14'h0600, `PPTC_RESP_SLVERR, v);
        `CHK(v, 32'h0)
        // nominal rate across a second boundary
        rate(1'b0, 1'b0, 2'd0);
        ld(32'($urandom), 32'd999_999_600, 3'h3, 16'h0000);
        mark();
        span();
        `CHK(ns, exp_ns(n0, 0))
        `CHK(sec, s0 + 32'd1)
        // continuous and temporary modes, both directions
        // upper duration word still holds its random readback value
        wr(`PPTC_IDX_DUR_HI, 16'h0000, `PPTC_RESP_OKAY);
        for (int m = 0; m < 4; m++) begin
            k = 2'(1 + $urandom % 3);
            dv = 4 * (1 + $urandom % 60);
            ld(32'($urandom), 32'd1000, 3'(m), (m < 2) ? 16'h0004 : 16'h0000);
            if (m < 2) rate(m[0], 1'b0, k);
            else wr(`PPTC_IDX_DUR_LO, 16'(dv), `PPTC_RESP_OKAY);
            mark();
            if (m >= 2) rate(m[0], 1'b1, k);
            span();
            if (m < 2)
                `CHK(ns, exp_ns(n0, (m[0] ? 125 : -125) * int'(k)))
            else
                `CHK(ns, exp_ns(n0, (m[0] ? 1 : -1) * (dv / 4) * int'(k)))
            rd(`PPTC_IDX_RATE_HI, `PPTC_RESP_OKAY, v);
            `CHK(v[14], 1'b0)
            wr(`PPTC_IDX_CTRL, 16'h0000, `PPTC_RESP_OKAY);
        end
        // long temporary run stopped by software
        wr(`PPTC_IDX_DUR_HI, 16'h0001, `PPTC_RESP_OKAY);
        rate(1'b1, 1'b1, 2'd3);
        rate(1'b1, 1'b0, 2'd3);
        mark();
        span();
        `CHK(ns, exp_ns(n0, 0))
        // snapshot of the live clock into the words
        wr(`PPTC_IDX_CTRL, 16'h0010, `PPTC_RESP_OKAY);
        rd(`PPTC_IDX_NS_HI, `PPTC_RESP_OKAY, v);
        n0[31:16] = v[15:0];
        rd(`PPTC_IDX_NS_LO, `PPTC_RESP_OKAY, v);
        n0[15:0] = v[15:0];
        rd(`PPTC_IDX_SEC_LO, `PPTC_RESP_OKAY, v);
        @(negedge clk);
        `CHK(v[15:0], sec[15:0])
        v = ns - n0;
        `CHK((v % 40 == 0) && (v < 800), 1'b1)
        rd(`PPTC_IDX_CTRL, `PPTC_RESP_OKAY, v);
        `CHK(v, 32'h0)
        close_out();
    end
endmodule
